/* ssdp_ctrl_model.sv */
`timescale 1ns/1ps
`include "ssdp_map.svh"
// memory controller: commands just after each edge, write data one edge later
module ssdp_ctrl_model (
    input  wire logic                           clk_sys_i,
    output logic                                clock_gate_n_o,
    output logic                                cs1_n_o,
    output logic                                cs2_o,
    output logic                                cs3_n_o,
    output logic                                we_n_o,
    output logic [`SSDP_LANES-1:0]              lane_sel_n_o,
    output logic                                adv_o,
    output logic [`SSDP_ADDR_W-1:0]             addr_o,
    output logic                                oe_n_o,
    output logic                                mode_o,
    output logic [`SSDP_LANES*`SSDP_BYTE_W-1:0] dq_o,
    output logic [`SSDP_LANES-1:0]              par_o,
    output logic                                drive_o
);
    logic        pend;   // write data owed at the next edge
    logic [35:0] pend_d; // parity and data owed
    // idle at time zero: deselected, clock recognised
    initial
    begin
        clock_gate_n_o = 1'b0;
        cs1_n_o = 1'b1;
        cs2_o = 1'b1;
        cs3_n_o = 1'b0;
        we_n_o = 1'b1;
        lane_sel_n_o = 4'hF;
        adv_o = 1'b0;
        addr_o = 8'h00;
        oe_n_o = 1'b0;
        mode_o = 1'b1;
        {par_o, dq_o} = 36'h0_0000_0000;
        drive_o = 1'b0;
        pend = 1'b0;
        pend_d = 36'h0_0000_0000;
    end
    // one command per edge; owed write data goes out with it
    task automatic step(input ssdp_pkg::ssdp_op_e op, input logic adv,
                        input logic [7:0] a, input logic [3:0] ls_n, input logic [35:0] wd);
        @(posedge clk_sys_i);
        #1;
        clock_gate_n_o = 1'b0;
        drive_o = pend;
        if (pend)
            {par_o, dq_o} = pend_d;
        pend = (op == ssdp_pkg::op_write);
        pend_d = wd;
        cs1_n_o = (op == ssdp_pkg::op_desel);
        we_n_o = (op != ssdp_pkg::op_write);
        lane_sel_n_o = ls_n;
        adv_o = adv;
        addr_o = a;
    endtask
    // gate the clock for n edges with advance requested
    task automatic hold(input int n);
        repeat (n)
        begin
            @(posedge clk_sys_i);
            #1;
            clock_gate_n_o = 1'b1;
            adv_o = 1'b1;
            drive_o = 1'b0;
        end
    endtask
endmodule // ssdp_ctrl_model

/* ssdp_data_port.sv */
`timescale 1ns/1ps
`include "ssdp_map.svh"
// data and parity port of a synchronous flow-through burst memory
module ssdp_data_port #(
    parameter int ADDR_W     = `SSDP_ADDR_W,
    parameter int FIFO_DEPTH = `SSDP_FIFO_DEPTH
) (
    input  wire logic                                 clk_sys_i,
    input  wire logic                                 rst_i,
    input  wire logic                                 clock_gate_n_i,
    input  wire logic                                 chip_select_1_n_i,
    input  wire logic                                 chip_select_2_i,
    input  wire logic                                 chip_select_3_n_i,
    input  wire logic                                 write_enable_n_i,
    input  wire logic [`SSDP_LANES-1:0]               byte_write_select_n_i,
    input  wire logic                                 advance_load_i,
    input  wire logic [ADDR_W-1:0]                    addr_i,
    input  wire logic                                 output_enable_n_i,
    input  wire logic                                 burst_mode_i,
    input  wire logic [`SSDP_LANES*`SSDP_BYTE_W-1:0]  dq_i,
    output logic      [`SSDP_LANES*`SSDP_BYTE_W-1:0]  dq_o,
    output logic                                      dq_oe_o,
    input  wire logic [`SSDP_LANES-1:0]               parity_lines_i,
    output logic      [`SSDP_LANES-1:0]               parity_lines_o,
    output logic                                      parity_lines_oe_o,
    output logic                                      write_ready_o
);
    localparam int DW = `SSDP_LANES * `SSDP_BYTE_W;
    localparam int WW = $bits(ssdp_pkg::ssdp_wr_s);

    // queued write record is fixed by the package
    initial
    begin
        if (ADDR_W != `SSDP_ADDR_W || ADDR_W < `SSDP_CNT_W + 1)
            $error("ssdp_data_port: ADDR_W must match the write record");
    end

    // burst address: linear adds offset, interleaved xors it
    function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                     input logic [`SSDP_CNT_W-1:0] offs,
                                                     input logic linear);
        logic [`SSDP_CNT_W-1:0] lo;
        lo = linear ? (base[`SSDP_CNT_W-1:0] + offs) : (base[`SSDP_CNT_W-1:0] ^ offs);
        return {base[ADDR_W-1:`SSDP_CNT_W], lo};
    endfunction

    logic                     oe_meta_r;                 // output enable sync stage 1
    logic                     oe_n_s_r;                  // output enable synchronised
    logic                     mode_meta_r;               // strap sync stage 1
    logic                     mode_s_r;                  // strap synchronised
    ssdp_pkg::ssdp_op_e       op_r;                      // operation of current cycle
    ssdp_pkg::ssdp_op_e       op_nxt;                    // operation after this edge
    logic                     first_r;                   // first cycle after deselect
    logic [ADDR_W-1:0]        base_r;                    // loaded burst base address
    logic [`SSDP_CNT_W-1:0]   cnt_r;                     // burst offset counter
    logic [`SSDP_CNT_W-1:0]   cnt_nxt;                   // burst offset after this edge
    logic [ADDR_W-1:0]        acc_addr;                  // address taken at this edge
    logic [ADDR_W-1:0]        waddr_r;                   // address of pending write data
    logic [`SSDP_LANES-1:0]   wmask_r;                   // lanes of pending write data
    logic [DW-1:0]            din_r;                     // captured data lines
    logic [`SSDP_LANES-1:0]   pin_r;                     // captured parity lines
    logic [DW-1:0]            rdata_r;                   // read data register
    logic [`SSDP_LANES-1:0]   rpar_r;                    // read parity register
    logic                     en;                        // clock edge recognised
    logic                     load;                      // new address taken
    logic                     selected;                  // chip selects all active
    logic                     linear;                    // linear burst order
    logic                     rd_take;                   // read access this edge
    logic                     push;                      // write data enters the queue
    ssdp_pkg::ssdp_wr_s       push_rec;                  // record pushed
    ssdp_pkg::ssdp_wr_s       drain_rec;                 // record at queue head
    logic                     drain_valid;               // queue holds a record
    logic                     drain_ready;               // array may take a record
    logic [DW-1:0]            rd_word;                   // array word at access address
    logic [`SSDP_LANES-1:0]   rd_pword;                  // parity at access address

    // async output enable and strap pass two flops
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            oe_meta_r   <= 1'b1;
            oe_n_s_r    <= 1'b1;
            mode_meta_r <= 1'b1;
            mode_s_r    <= 1'b1;
        end
        else
        begin
            oe_meta_r   <= output_enable_n_i;
            oe_n_s_r    <= oe_meta_r;
            mode_meta_r <= burst_mode_i;
            mode_s_r    <= mode_meta_r;
        end
    end

    assign en       = !clock_gate_n_i;                          // see RQ12
    assign load     = !advance_load_i;
    assign selected = !chip_select_1_n_i && chip_select_2_i && !chip_select_3_n_i;
    assign linear   = !mode_s_r;                                // see RQ8
    assign cnt_nxt  = load ? `SSDP_CNT_RST : cnt_r + 1'b1;      // see RQ13
    assign acc_addr = load ? addr_i : burst_addr(base_r, cnt_nxt, linear); // see RQ8
    assign rd_take  = en && (op_nxt == ssdp_pkg::op_read);

    // next operation: load decodes selects, advance keeps the burst
    always_comb
    begin
        op_nxt = op_r;
        if (load)
        begin
            if (!selected)
                op_nxt = ssdp_pkg::op_desel;
            else if (!write_enable_n_i)
                op_nxt = ssdp_pkg::op_write;
            else
                op_nxt = ssdp_pkg::op_read;
        end
    end

    // operation, burst counter and deselect-exit flag
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            op_r    <= ssdp_pkg::op_desel;
            first_r <= 1'b0;
            base_r  <= '0;
            cnt_r   <= `SSDP_CNT_RST;
        end
        else if (en)                                            // see RQ12
        begin
            op_r    <= op_nxt;
            first_r <= (op_r == ssdp_pkg::op_desel) && (op_nxt != ssdp_pkg::op_desel);
            cnt_r   <= cnt_nxt;                                 // see RQ13
            if (load)
                base_r <= addr_i;
        end
    end

    // write address and lane mask wait one edge for their data
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            waddr_r <= '0;
            wmask_r <= '0;
        end
        else if (en)
        begin
            waddr_r <= acc_addr;
            // selects only count together with an active write
            case (op_nxt)
                ssdp_pkg::op_write: wmask_r <= ~byte_write_select_n_i; // see RQ10
                default:            wmask_r <= '0;
            endcase
        end
    end

    // data and parity lines captured on every recognised edge
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            din_r <= '0;
            pin_r <= '0;
        end
        else if (en)
        begin
            din_r <= dq_i;                                      // see RQ1
            pin_r <= parity_lines_i;                            // see RQ7
        end
    end

    // read register loads the word for the address taken now
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_r <= '0;
            rpar_r  <= '0;
        end
        else if (rd_take)
        begin
            rdata_r <= rd_word;                                 // see RQ2
            rpar_r  <= rd_pword;                                // see RQ7
        end
    end

    // write data of the cycle enters the queue on its edge
    assign push          = en && (op_r == ssdp_pkg::op_write);
    assign push_rec.addr = waddr_r;
    assign push_rec.mask = wmask_r;
    assign push_rec.par  = parity_lines_i;
    assign push_rec.data = dq_i;
    // array port is given to reads first, so the queue can fill
    assign drain_ready   = !rd_take;

    ssdp_fifo #(
        .W     (WW),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (push),
        .in_ready_o  (write_ready_o),
        .in_data_i   (push_rec),
        .out_valid_o (drain_valid),
        .out_ready_i (drain_ready),
        .out_data_o  (drain_rec)
    );

    // array per lane, parity with its own lane; one writer per array
    for (genvar g = 0; g < `SSDP_LANES; g++)
    begin : g_lane
        logic [`SSDP_BYTE_W-1:0] mem_byte_r [1 << ADDR_W];   // lane data bytes
        logic                    mem_pbit_r [1 << ADDR_W];   // lane parity bits

        // lane update when the queue head selects this lane
        always_ff @(posedge clk_sys_i)
        begin
            if (drain_valid && drain_ready && drain_rec.mask[g])
            begin
                mem_byte_r[drain_rec.addr] <= drain_rec.data[g*`SSDP_BYTE_W +: `SSDP_BYTE_W];
                mem_pbit_r[drain_rec.addr] <= drain_rec.par[g];   // see RQ7
            end
        end

        // lane share of the word at the access address
        assign rd_word[g*`SSDP_BYTE_W +: `SSDP_BYTE_W] = mem_byte_r[acc_addr];
        assign rd_pword[g]                             = mem_pbit_r[acc_addr];
    end

    // drive only in a read, past deselect exit, with enable low
    assign dq_oe_o = !oe_n_s_r && (op_r == ssdp_pkg::op_read) && !first_r; // see RQ3 RQ4 RQ5 RQ6 RQ11
    assign parity_lines_oe_o = dq_oe_o;                         // see RQ7
    assign dq_o              = rdata_r;
    assign parity_lines_o    = rpar_r;

    capture_lines_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ1
        en |=> (din_r == $past(dq_i)) && (pin_r == $past(parity_lines_i)))
        else $error("data lines not captured");
    flow_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ2
        rd_take |=> (dq_o == $past(rd_word)) && (parity_lines_o == $past(rd_pword)))
        else $error("read data not for previous edge address");
    oe_high_tri_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ3
        oe_n_s_r |-> !dq_oe_o && !parity_lines_oe_o)
        else $error("driving with output enable high");
    write_phase_tri_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ4
        (en && op_nxt == ssdp_pkg::op_write) |=> !dq_oe_o)
        else $error("driving during write data");
    desel_exit_tri_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ5
        (en && op_r == ssdp_pkg::op_desel && op_nxt != ssdp_pkg::op_desel) |=> !dq_oe_o)
        else $error("driving on first cycle after deselect");
    desel_tri_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ6
        (op_r == ssdp_pkg::op_desel) |-> !dq_oe_o)
        else $error("driving while deselected");
    read_drive_on_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ11
        (op_r == ssdp_pkg::op_read && !first_r && !oe_n_s_r) |-> dq_oe_o && parity_lines_oe_o)
        else $error("read with enable low not driven");
    byte_select_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ10
        (en && load && write_enable_n_i) |=> (wmask_r == '0))
        else $error("byte selects acted without write enable");
    gate_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ12
        !en |=> $stable(op_r) && $stable(cnt_r) && $stable(din_r))
        else $error("state moved on a gated edge");
    burst_step_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ13
        (en && !load) |=> (cnt_r == $past(cnt_r) + 2'h1))
        else $error("burst counter did not advance");
    linear_order_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see RQ8
        (!load && linear) |-> (acc_addr[1:0] == 2'(base_r[1:0] + cnt_nxt)))
        else $error("linear burst order wrong");
endmodule // ssdp_data_port

/* ssdp_fifo.sv */
`timescale 1ns/1ps
// small synchronous queue with valid/ready on both sides
module ssdp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);

    // depth must be a power of two for pointer wrap
    initial
    begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || W < 1)
            $error("ssdp_fifo: unsupported W or DEPTH");
    end

    logic [W-1:0]  mem_r [DEPTH];   // storage words
    logic [PW:0]   wr_ptr_r;        // write pointer with wrap bit
    logic [PW:0]   rd_ptr_r;        // read pointer with wrap bit
    logic          push;            // word accepted
    logic          pop;             // word drained

    // full when pointers differ only in wrap bit
    assign in_ready_o  = !((wr_ptr_r[PW] != rd_ptr_r[PW]) &&
                           (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]));
    assign out_valid_o = (wr_ptr_r != rd_ptr_r);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_r[rd_ptr_r[PW-1:0]];

    // storage write, no reset needed
    always_ff @(posedge clk_sys_i)
    begin
        if (push)
            mem_r[wr_ptr_r[PW-1:0]] <= in_data_i;
    end

    // pointers
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule // ssdp_fifo

/* ssdp_map.svh */
// What this block does
// RQ1: capture data lines every enabled rising edge
// RQ2: flow-through read data for previous-edge address
// RQ3: drivers on only while output enable low
// RQ4: outputs tri-stated during write data phase
// RQ5: tri-state first clock after leaving deselect
// RQ6: outputs tri-stated whenever device is deselected
// RQ7: parity acts as data, gated per lane
// RQ8: strap low linear, high interleaved burst
// RQ9: controller holds burst strap constant; the testbench changes mode_o between bursts in t_burst
// RQ10: byte selects sampled, effective only with write
// RQ11: async output enable combined with sync state
// RQ12: gated clock edges hold every state except the enable and strap syncs and the write queue drain
// RQ13: two-bit burst counter loads, advances
// RQ14: controller releases data lines expecting reads
`ifndef SSDP_MAP_SVH
`define SSDP_MAP_SVH
// word address width of the array
`define SSDP_ADDR_W     8
// byte lanes, each with one parity line
`define SSDP_LANES      4
// data bits per lane
`define SSDP_BYTE_W     8
// write queue depth
`define SSDP_FIFO_DEPTH 16
// burst offset after reset
`define SSDP_CNT_RST    2'h0
// burst counter width
`define SSDP_CNT_W      2
`endif

/* ssdp_pkg.sv */
`include "ssdp_map.svh"
package ssdp_pkg;
    // operation held for the cycle after an edge
    typedef enum logic [1:0] {op_desel, op_read, op_write} ssdp_op_e;
    // one queued write: address, lane mask, parity and data
    typedef struct packed {
        logic [`SSDP_ADDR_W-1:0]             addr;
        logic [`SSDP_LANES-1:0]              mask;
        logic [`SSDP_LANES-1:0]              par;
        logic [`SSDP_LANES*`SSDP_BYTE_W-1:0] data;
    } ssdp_wr_s;
endpackage

/* testbench.sv */
`timescale 1ns/1ps
`include "ssdp_map.svh"
module testbench;
    logic        clk_sys_i, rst_i;                     // clock and reset
    logic        gate_n, cs1_n, cs2, cs3_n, we_n, adv; // controls
    logic        oe_n, mode, drv, dq_oe, par_oe, wr_rdy;
    logic [3:0]  lane_n, cpar, par_o, par_bus;         // lane selects, parity
    logic [7:0]  addr;                                 // word address
    logic [31:0] cdq, dq_o, dq_bus;                    // data lines
    logic [35:0] exp_mem [256];                        // expected array
    int          n_mismatch = 0;
    int          check_count = 0;
    // shared lines: device, else controller, else drifting
    assign dq_bus  = dq_oe ? dq_o : (drv ? cdq : ~cdq);
    assign par_bus = par_oe ? par_o : (drv ? cpar : ~cpar);
    ssdp_ctrl_model u_ctl (.clk_sys_i(clk_sys_i), .clock_gate_n_o(gate_n), .cs1_n_o(cs1_n),
        .cs2_o(cs2), .cs3_n_o(cs3_n), .we_n_o(we_n), .lane_sel_n_o(lane_n), .adv_o(adv),
        .addr_o(addr), .oe_n_o(oe_n), .mode_o(mode), .dq_o(cdq), .par_o(cpar), .drive_o(drv));
    ssdp_data_port u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clock_gate_n_i(gate_n),
        .chip_select_1_n_i(cs1_n), .chip_select_2_i(cs2), .chip_select_3_n_i(cs3_n),
        .write_enable_n_i(we_n), .byte_write_select_n_i(lane_n), .advance_load_i(adv),
        .addr_i(addr), .output_enable_n_i(oe_n), .burst_mode_i(mode), .dq_i(dq_bus),
        .dq_o(dq_o), .dq_oe_o(dq_oe), .parity_lines_i(par_bus), .parity_lines_o(par_o),
        .parity_lines_oe_o(par_oe), .write_ready_o(wr_rdy));
    // 25 MHz clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // compare and count
    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // write with lane selects, tracking the expected array
    task automatic wr(input logic [7:0] a, input logic [3:0] bn, input logic [35:0] wd);
        u_ctl.step(ssdp_pkg::op_write, 1'b0, a, bn, wd);
        for (int g = 0; g < 4; g++)
            if (!bn[g])
            begin
                exp_mem[a][8*g +: 8] = wd[8*g +: 8];
                exp_mem[a][32+g] = wd[32+g];
            end
    endtask
    // load a read
    task automatic rd(input logic [7:0] a);
        u_ctl.step(ssdp_pkg::op_read, 1'b0, a, 4'hF, 36'h0_0000_0000);
    endtask
    // deselected cycles
    task automatic idle(input int n);
        repeat (n) u_ctl.step(ssdp_pkg::op_desel, 1'b0, 8'h00, 4'hF, 36'h0_0000_0000);
    endtask
    // fill four words, read back; first read out of deselect not driven
    task automatic t_write_read();
        for (int i = 0; i < 4; i++)
            wr(8'h20 + 8'(i), 4'h0, {4'(i), 32'hC0DE_0000 | 32'(i)});
        idle(6);
        rd(8'h20);
        for (int i = 1; i < 5; i++)
        begin
            if (i < 4)
                rd(8'h20 + 8'(i));
            else
                idle(1);
            chk("read word", {par_o, dq_o}, exp_mem[8'h1F + 8'(i)]);
            chk("data drive", 36'(dq_oe), 36'(i > 1));
            chk("parity drive", 36'(par_oe), 36'(i > 1));
        end
    endtask
    // partial lanes; selects with a read write nothing
    task automatic t_lanes();
        wr(8'h21, 4'hA, 36'hF_FFFF_FFFF);
        u_ctl.step(ssdp_pkg::op_read, 1'b0, 8'h22, 4'h0, 36'h0_0000_0000);
        idle(6);
        rd(8'h21);
        rd(8'h22);
        chk("lane merge", {par_o, dq_o}, 36'h5_C0FF_00FF);
        idle(1);
        chk("select without write", {par_o, dq_o}, exp_mem[8'h22]);
    endtask
    // output enable high keeps lines released, low again restores drive
    task automatic t_oe();
        u_ctl.oe_n_o = 1'b1;
        idle(3);
        rd(8'h20);
        rd(8'h20);
        idle(1);
        chk("drive with enable high", 36'(dq_oe), 36'h0);
        chk("parity with enable high", 36'(par_oe), 36'h0);
        u_ctl.oe_n_o = 1'b0;
        rd(8'h20);
        rd(8'h20);
        rd(8'h20);
        chk("drive after enable low", 36'(dq_oe), 36'h1);
    endtask
    // write then deselect, then reads with select 2 low, enable held low
    task automatic t_write_phase();
        wr(8'h30, 4'h0, 36'h3_1234_5678);
        idle(1);
        chk("drive in write data", 36'(dq_oe), 36'h0);
        idle(1);
        chk("drive when deselected", 36'(dq_oe), 36'h0);
        // second select low deselects although the first one is active
        u_ctl.cs2_o = 1'b0;
        rd(8'h30);
        rd(8'h30);
        rd(8'h30);
        chk("drive with select 2 low", 36'(dq_oe), 36'h0);
        u_ctl.cs2_o = 1'b1;
    endtask
    // burst from offset 1 in either order
    task automatic t_burst(input logic m);
        logic [1:0] o;
        u_ctl.mode_o = m;
        idle(3);
        rd(8'h21);
        rd(8'h21);
        for (int c = 0; c < 4; c++)
        begin
            if (c < 3)
                u_ctl.step(ssdp_pkg::op_read, 1'b1, 8'h00, 4'hF, 36'h0_0000_0000);
            else
                idle(1);
            o = m ? (2'h1 ^ 2'(c)) : (2'h1 + 2'(c));
            chk("burst word", {par_o, dq_o}, exp_mem[{6'h08, o}]);
        end
    endtask
    // gated edges neither advance nor deselect
    task automatic t_gate();
        rd(8'h20);
        rd(8'h20);
        u_ctl.hold(3);
        chk("word while gated", {par_o, dq_o}, exp_mem[8'h20]);
        chk("drive while gated", 36'(dq_oe), 36'h1);
        u_ctl.step(ssdp_pkg::op_read, 1'b1, 8'h00, 4'hF, 36'h0_0000_0000);
        idle(1);
        chk("advance after gate", {par_o, dq_o}, exp_mem[8'h21]);
    endtask
    // watchdog
    initial
    begin
        repeat (3000) @(posedge clk_sys_i);
        n_mismatch++;
        stop_test();
    end
    // main sequence
    initial
    begin
        rst_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("drive in reset", 36'(dq_oe), 36'h0);
        chk("ready in reset", 36'(wr_rdy), 36'h1);
        @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        t_write_read();
        t_lanes();
        t_oe();
        t_write_phase();
        t_burst(1'b0);
        t_burst(1'b1);
        t_gate();
        stop_test();
    end
endmodule // testbench
